// file: rtl/qsc_pkg.sv
// constants, types and register map shared by the channel status block
package qsc_pkg;

   // channel count and fifo geometry
   localparam int NCH            = 4;
   localparam int LVL_W          = 8;
   localparam int FIFO_DEPTH_DEF = 128;

   // apb address layout: paddr[7] global, paddr[6:5] channel
   localparam int PADDR_W    = 8;
   localparam int GLB_BIT    = 7;
   localparam int CH_LSB     = 5;
   localparam int CH_MSB     = 6;
   localparam int OFS_MSB    = 4;

   // per-channel register offsets
   localparam logic [4:0] OFS_FIFO_CTL = 5'h00;
   localparam logic [4:0] OFS_FEAT_CTL = 5'h04;
   localparam logic [4:0] OFS_ENH_MODE = 5'h08;
   localparam logic [4:0] OFS_LINE_ST  = 5'h0c;
   localparam logic [4:0] OFS_TRIG     = 5'h10;
   localparam logic [4:0] OFS_DIVISOR  = 5'h14;
   localparam logic [4:0] OFS_WORD_LEN = 5'h18;

   // global register offsets (channel field ignored)
   localparam logic [4:0] OFS_IRQ_STAT = 5'h00;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h04;

   // field positions
   localparam int FCR_FIFO_EN   = 0;
   localparam int FCR_BLOCK     = 3;
   localparam int FEATURE_CTL_REG_TX_EMPTY = 3;
   localparam int ENH_MODE_SELECT_REG_RX_XFER  = 2;
   localparam int ENH_MODE_SELECT_REG_TX_XFER  = 3;
   localparam int LSR_THR_EMPTY = 5;
   localparam int LSR_TX_EMPTY  = 6;
   localparam int TRG_TX_LSB    = 0;
   localparam int TRG_RX_LSB    = 8;

   // interrupt status layout: [3:0] rx ready, [7:4] timeout, [11:8] tc
   localparam int IRQ_W      = 12;
   localparam int IRQ_RX_LSB = 0;
   localparam int IRQ_TO_LSB = 4;
   localparam int IRQ_TC_LSB = 8;

   // reset values
   localparam logic [7:0]  CTL_RST  = 8'h00;
   localparam logic [15:0] TRG_RST  = 16'h0101;
   localparam logic [15:0] DIV_RST  = 16'h0001;
   localparam logic [1:0]  WLEN_RST = 2'h3;
   localparam logic [IRQ_W-1:0] IRQ_RST = 12'h000;

   // receive timeout timing, in bit times
   localparam int SAMPLES_PER_BIT = 16;
   localparam int TMO_CHARS       = 4;
   localparam int TMO_EXTRA_BITS  = 12;
   localparam int CHAR_BASE_BITS  = 7;
   localparam int TMO_W           = 6;

   typedef logic [LVL_W-1:0] qsc_lvl_t;

   // per-channel view of the fifo and transmitter datapath
   typedef struct packed {
      qsc_lvl_t tx_level;
      qsc_lvl_t rx_level;
      logic     tsr_empty;
      logic     rx_push;
      logic     rx_pop;
   } qsc_chan_in_t;

   // block-transfer receive-ready state
   typedef enum logic {
      RDY_IDLE = 1'b0,
      RDY_HELD = 1'b1
   } qsc_rdy_state_t;

endpackage : qsc_pkg

// file: rtl/qsc_status_top.sv
// per-channel status outputs of a quad uart with apb register access
//
// Overview of operation
// - fifo off: tx interrupt follows holding or transmitter
// - fifo on, bit clear: high below trigger or empty
// - fifo on: low at or above trigger; bit set uses tx-empty
// - rx interrupt: byte held, or at or above trigger
// - normal mode: rx ready low while data held
// - normal mode: tx ready low when holding empty
// - block mode: tx ready low unless fifo full
// - block mode: rx ready falls at trigger or timeout
// - block mode: rx ready held low until empty
// - transfer requests enabled only by mode bits 2,3
// - requests, acknowledge, qualifier and terminal count coordinate
// - fifo on, block bit clear: single-character signalling
// - line status bits 5,6 report tx room, empty
// - one clock feeds every channel baud divider
// - bus transfers complete without baud clock activity
// - timeout after four characters plus twelve bits
module qsc_status_top #(
   parameter int FIFO_DEPTH = qsc_pkg::FIFO_DEPTH_DEF
) (
   input  wire logic                                   clock,
   input  wire logic                                   rst_n,
   input  wire logic                                   psel,
   input  wire logic                                   penable,
   input  wire logic                                   pwrite,
   input  wire logic [qsc_pkg::PADDR_W-1:0]            paddr,
   input  wire logic [31:0]                            pwdata,
   output logic      [31:0]                            prdata,
   output logic                                        pready,
   output logic                                        pslverr,
   input  wire qsc_pkg::qsc_chan_in_t [qsc_pkg::NCH-1:0] chan_in,
   input  wire logic [qsc_pkg::NCH-1:0]                transfer_acknowledge,
   input  wire logic                                   address_enable_qual,
   input  wire logic                                   transfer_terminal_count,
   output logic      [qsc_pkg::NCH-1:0]                tx_int_out,
   output logic      [qsc_pkg::NCH-1:0]                rx_int_out,
   output logic      [qsc_pkg::NCH-1:0]                tx_ready_out_n,
   output logic      [qsc_pkg::NCH-1:0]                rx_ready_out_n,
   output logic      [qsc_pkg::NCH-1:0]                tx_transfer_request,
   output logic      [qsc_pkg::NCH-1:0]                rx_transfer_request,
   output logic                                        irq
);
   import qsc_pkg::*;

   // mapped-address check, shared by the write path and the error answer
   function automatic logic addr_ok(input logic [PADDR_W-1:0] a);
      logic [4:0] o;
      o = a[OFS_MSB:0];
      if (a[GLB_BIT])
         addr_ok = (o == OFS_IRQ_STAT) || (o == OFS_IRQ_MASK);
      else
         addr_ok = (o == OFS_FIFO_CTL) || (o == OFS_FEAT_CTL) ||
                   (o == OFS_ENH_MODE) || (o == OFS_LINE_ST)  ||
                   (o == OFS_TRIG)     || (o == OFS_DIVISOR)  ||
                   (o == OFS_WORD_LEN);
   endfunction : addr_ok

   // software registers, one set per channel, plus the global interrupt status and mask
   logic [7:0]       fifo_ctl_reg        [NCH];
   logic [7:0]       feature_ctl_reg     [NCH];
   logic [7:0]       enh_mode_select_reg [NCH];
   logic [15:0]      trig_reg            [NCH];
   logic [15:0]      divisor_reg         [NCH];
   logic [1:0]       word_len_reg        [NCH];
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [7:0]       line_status_reg     [NCH];

   // apb slave state
   logic        pready_reg;
   logic        pslverr_reg;
   logic [31:0] prdata_reg;

   // channel status state
   logic [15:0]          div_cnt_reg  [NCH];
   logic [3:0]           samp_cnt_reg [NCH];
   logic [TMO_W-1:0]     bit_cnt_reg  [NCH];
   logic [NCH-1:0]       tmo_reg;
   logic [NCH-1:0]       tc_hold_reg;
   qsc_rdy_state_t       rdy_state_reg  [NCH];
   qsc_rdy_state_t       rdy_state_next [NCH];

   // output flops and their next values
   logic [NCH-1:0] tx_int_reg,  tx_int_next;
   logic [NCH-1:0] rx_int_reg,  rx_int_next;
   logic [NCH-1:0] tx_rdy_reg,  tx_rdy_next;
   logic [NCH-1:0] rx_rdy_reg,  rx_rdy_next;
   logic [NCH-1:0] tx_req_reg,  tx_req_next;
   logic [NCH-1:0] rx_req_reg,  rx_req_next;
   logic           irq_reg;

   // per-channel events for the interrupt status
   logic [NCH-1:0] ev_rx;
   logic [NCH-1:0] ev_tmo;
   logic [NCH-1:0] ev_tc;

   // apb decode; no baud tick gates any of it, answer is one wait-free
   // access phase after setup
   wire logic       setup   = psel & ~penable;
   wire logic       access  = psel & penable & pready_reg;
   wire logic       glb     = paddr[GLB_BIT];
   wire logic [4:0] ofs     = paddr[OFS_MSB:0];
   wire logic [1:0] ch      = paddr[CH_MSB:CH_LSB];
   wire logic       hit     = addr_ok(paddr);
   wire logic       wr_go   = access & pwrite & hit;
   wire logic       stat_rd = access & ~pwrite & glb &
                              (ofs == OFS_IRQ_STAT);

   // read data selection, computed in setup and held through access
   wire logic [31:0] rd_ch =
      (ofs == OFS_FIFO_CTL) ? 32'(fifo_ctl_reg[ch]) :
      (ofs == OFS_FEAT_CTL) ? 32'(feature_ctl_reg[ch]) :
      (ofs == OFS_ENH_MODE) ? 32'(enh_mode_select_reg[ch]) :
      (ofs == OFS_LINE_ST)  ? 32'(line_status_reg[ch]) :
      (ofs == OFS_TRIG)     ? 32'(trig_reg[ch]) :
      (ofs == OFS_DIVISOR)  ? 32'(divisor_reg[ch]) :
      (ofs == OFS_WORD_LEN) ? 32'(word_len_reg[ch]) :
                              32'h00000000;
   wire logic [31:0] rd_glb =
      (ofs == OFS_IRQ_STAT) ? 32'(irq_stat_reg) :
      (ofs == OFS_IRQ_MASK) ? 32'(irq_mask_reg) :
                              32'h00000000;
   wire logic [31:0] rd_word = ~hit ? 32'h00000000 :
                               glb  ? rd_glb : rd_ch;

   // apb answer flops; unmapped addresses answer with pslverr
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup & ~hit;
         if (setup) prdata_reg <= rd_word;
      end
   end

   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;
   assign prdata  = prdata_reg;

   // interrupt status: a read clears only the bits it reported, so an
   // event landing between setup and access is not lost
   wire logic [IRQ_W-1:0] ev_all  = {ev_tc, ev_tmo, ev_rx};
   wire logic [IRQ_W-1:0] clr_all = {IRQ_W{stat_rd}} &
                                    prdata_reg[IRQ_W-1:0];
   wire logic [IRQ_W-1:0] stat_next = (irq_stat_reg & ~clr_all) | ev_all;
   wire logic             mask_wr   = wr_go & glb & (ofs == OFS_IRQ_MASK);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_reg <= IRQ_RST;
         irq_mask_reg <= IRQ_RST;
         irq_reg      <= 1'b0;
      end else begin
         irq_stat_reg <= stat_next;
         if (mask_wr) irq_mask_reg <= pwdata[IRQ_W-1:0];
         irq_reg <= |(stat_next & irq_mask_reg);
      end
   end

   assign irq = irq_reg;

   // each channel is a full copy with only its own levels and settings
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      wire logic wr_ch = wr_go & ~glb & (ch == 2'(g));

      // software writes to this channel
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            fifo_ctl_reg[g]        <= CTL_RST;
            feature_ctl_reg[g]     <= CTL_RST;
            enh_mode_select_reg[g] <= CTL_RST;
            trig_reg[g]            <= TRG_RST;
            divisor_reg[g]         <= DIV_RST;
            word_len_reg[g]        <= WLEN_RST;
         end else if (wr_ch) begin
            if (ofs == OFS_FIFO_CTL) fifo_ctl_reg[g] <= pwdata[7:0];
            if (ofs == OFS_FEAT_CTL) feature_ctl_reg[g] <= pwdata[7:0];
            if (ofs == OFS_ENH_MODE) enh_mode_select_reg[g] <= pwdata[7:0];
            if (ofs == OFS_TRIG)     trig_reg[g] <= pwdata[15:0];
            if (ofs == OFS_DIVISOR)  divisor_reg[g] <= pwdata[15:0];
            if (ofs == OFS_WORD_LEN) word_len_reg[g] <= pwdata[1:0];
         end
      end

      // mode and level decode
      wire logic     fifo_en  = fifo_ctl_reg[g][FCR_FIFO_EN];
      wire logic     blk_bit  = fifo_ctl_reg[g][FCR_BLOCK];
      wire logic     blk_mode = fifo_en & blk_bit;
      wire logic     tx_sel   = feature_ctl_reg[g][FEATURE_CTL_REG_TX_EMPTY];
      wire qsc_lvl_t tx_lvl   = chan_in[g].tx_level;
      wire qsc_lvl_t rx_lvl   = chan_in[g].rx_level;
      wire qsc_lvl_t tx_trg   = trig_reg[g][TRG_TX_LSB +: LVL_W];
      wire qsc_lvl_t rx_trg   = trig_reg[g][TRG_RX_LSB +: LVL_W];
      wire logic     thr_mt   = (tx_lvl == '0);
      wire logic     tx_mt    = thr_mt & chan_in[g].tsr_empty;
      wire logic     tx_full  = (tx_lvl >= LVL_W'(FIFO_DEPTH));
      wire logic     tx_below = (tx_lvl < tx_trg);
      wire logic     rx_have  = (rx_lvl != '0);
      wire logic     rx_at    = (rx_lvl >= rx_trg);

      // line status: room in transmitter and fully empty
      assign line_status_reg[g] =
         8'(({7'h00, thr_mt} << LSR_THR_EMPTY) |
            ({7'h00, tx_mt}  << LSR_TX_EMPTY));

      // baud divider per channel, all on the one shared clock
      wire logic [15:0] div_m1 = (divisor_reg[g] == 16'h0000) ? 16'h0000 :
                                 divisor_reg[g] - 16'h0001;
      wire logic samp_tick = (div_cnt_reg[g] >= div_m1);
      wire logic bit_tick  = samp_tick &
         (samp_cnt_reg[g] == 4'(SAMPLES_PER_BIT - 1));

      // timeout limit: four character lengths plus twelve bit times
      wire logic [TMO_W-1:0] tmo_lim = TMO_W'(TMO_CHARS *
         (CHAR_BASE_BITS + int'(word_len_reg[g])) + TMO_EXTRA_BITS);
      wire logic restart = chan_in[g].rx_push | chan_in[g].rx_pop |
                           ~rx_have;
      wire logic tmo_hit = ~restart & (bit_cnt_reg[g] == tmo_lim);
      assign ev_tmo[g]   = tmo_hit & ~tmo_reg[g];

      // timeout counters; traffic or an empty fifo restarts the wait
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            div_cnt_reg[g]  <= 16'h0000;
            samp_cnt_reg[g] <= 4'h0;
            bit_cnt_reg[g]  <= '0;
            tmo_reg[g]      <= 1'b0;
         end else begin
            div_cnt_reg[g]  <= samp_tick ? 16'h0000 :
                               div_cnt_reg[g] + 16'h0001;
            if (samp_tick) samp_cnt_reg[g] <= samp_cnt_reg[g] + 4'h1;
            if (restart)
               bit_cnt_reg[g] <= '0;
            else if (bit_tick && bit_cnt_reg[g] != tmo_lim)
               bit_cnt_reg[g] <= bit_cnt_reg[g] + 1'b1;
            tmo_reg[g] <= restart ? 1'b0 : (tmo_reg[g] | tmo_hit);
         end
      end

      wire logic tmo_now = tmo_reg[g] | tmo_hit;

      // transmit interrupt level
      assign tx_int_next[g] =
         ~fifo_en ? (tx_sel ? tx_mt : thr_mt) :
         tx_sel   ? (tx_below | tx_mt) :
                    (tx_below | thr_mt);

      // receive interrupt level; without block mode the timeout also
      // raises it so a short tail is not stranded
      assign rx_int_next[g] =
         ~fifo_en ? rx_have :
         blk_bit  ? rx_at : (rx_at | tmo_now);

      // block-mode receive-ready hold
      always_comb begin
         rdy_state_next[g] = RDY_IDLE;
         if (blk_mode) begin
            unique case (rdy_state_reg[g])
               RDY_IDLE: begin
                  if (rx_at || tmo_now)
                     rdy_state_next[g] = RDY_HELD;
               end
               RDY_HELD: begin
                  if (!rx_have)
                     rdy_state_next[g] = RDY_IDLE;
                  else
                     rdy_state_next[g] = RDY_HELD;
               end
            endcase
         end
      end

      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) rdy_state_reg[g] <= RDY_IDLE;
         else        rdy_state_reg[g] <= rdy_state_next[g];
      end

      // ready pins: per character unless block mode
      assign rx_rdy_next[g] = blk_mode ?
         (rdy_state_next[g] == RDY_IDLE) :
         ~rx_have;
      assign tx_rdy_next[g] = blk_mode ? tx_full :
                              ~thr_mt;
      assign ev_rx[g] = rx_rdy_reg[g] & ~rx_rdy_next[g];

      // transfer handshake: an acknowledge counts only with the
      // qualifier; terminal count parks requests until the channel
      // goes idle, so the controller is not asked past its block end
      wire logic ack_q  = transfer_acknowledge[g] &
                          address_enable_qual;
      wire logic tc_now = ack_q & transfer_terminal_count;
      wire logic idle   = rx_rdy_next[g] & tx_rdy_next[g];
      assign ev_tc[g]   = tc_now;

      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n)      tc_hold_reg[g] <= 1'b0;
         else if (tc_now) tc_hold_reg[g] <= 1'b1;
         else if (idle)   tc_hold_reg[g] <= 1'b0;
      end

      wire logic park = tc_hold_reg[g] | tc_now;
      assign rx_req_next[g] = enh_mode_select_reg[g][ENH_MODE_SELECT_REG_RX_XFER] &
                              ~rx_rdy_next[g] & ~park;
      assign tx_req_next[g] = enh_mode_select_reg[g][ENH_MODE_SELECT_REG_TX_XFER] &
                              ~tx_rdy_next[g] & ~park;
   end

   // every pin leaves from a flop, one cycle behind its cause
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_int_reg <= '0;
         rx_int_reg <= '0;
         tx_rdy_reg <= '1;
         rx_rdy_reg <= '1;
         tx_req_reg <= '0;
         rx_req_reg <= '0;
      end else begin
         tx_int_reg <= tx_int_next;
         rx_int_reg <= rx_int_next;
         tx_rdy_reg <= tx_rdy_next;
         rx_rdy_reg <= rx_rdy_next;
         tx_req_reg <= tx_req_next;
         rx_req_reg <= rx_req_next;
      end
   end

   assign tx_int_out          = tx_int_reg;
   assign rx_int_out          = rx_int_reg;
   assign tx_ready_out_n      = tx_rdy_reg;
   assign rx_ready_out_n      = rx_rdy_reg;
   assign tx_transfer_request = tx_req_reg;
   assign rx_transfer_request = rx_req_reg;

endmodule : qsc_status_top

// file: sim/qsc_status_properties.sv
// port-level checks of the channel status block
module qsc_status_properties #(
   parameter int FIFO_DEPTH = qsc_pkg::FIFO_DEPTH_DEF
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [qsc_pkg::PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire qsc_pkg::qsc_chan_in_t [qsc_pkg::NCH-1:0] chan_in,
   input wire logic [qsc_pkg::NCH-1:0] transfer_acknowledge,
   input wire logic address_enable_qual,
   input wire logic transfer_terminal_count,
   input wire logic [qsc_pkg::NCH-1:0] tx_int_out,
   input wire logic [qsc_pkg::NCH-1:0] rx_int_out,
   input wire logic [qsc_pkg::NCH-1:0] tx_ready_out_n,
   input wire logic [qsc_pkg::NCH-1:0] rx_ready_out_n,
   input wire logic [qsc_pkg::NCH-1:0] tx_transfer_request,
   input wire logic [qsc_pkg::NCH-1:0] rx_transfer_request,
   input wire logic irq
);
   import qsc_pkg::*;
   logic [NCH-1:0]   rx_emp, tx_emp, tx_full, xmt_emp;
   logic [IRQ_W-1:0] mask_reg;
   // level decodes, valid in every mode
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         rx_emp[c] = chan_in[c].rx_level == '0;
         tx_emp[c] = chan_in[c].tx_level == '0;
         tx_full[c] = chan_in[c].tx_level >= FIFO_DEPTH;
         xmt_emp[c] = tx_emp[c] & chan_in[c].tsr_empty;
      end
   end
   // shadow of the interrupt mask
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         mask_reg <= '0;
      else if (psel && penable && pready && pwrite && paddr == 8'h84)
         mask_reg <= pwdata[IRQ_W-1:0];
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_apb_ready: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_ready_once: assert property (pready |=> !pready)
      else $error("pready held");
   a_err_zero: assert property (pslverr |-> pready && prdata == '0)
      else $error("error answer with data");
   a_rx_empty: assert property ((rx_ready_out_n | ~$past(rx_emp)) == '1)
      else $error("rx ready, fifo empty");
   a_tx_empty: assert property ($past(rst_n) |->
      (tx_ready_out_n & $past(tx_emp)) == '0)
      else $error("tx busy, fifo empty");
   a_tx_full: assert property ((tx_ready_out_n | ~$past(tx_full)) == '1)
      else $error("tx ready, fifo full");
   a_txint_empty: assert property ($past(rst_n) |->
      (tx_int_out | ~$past(xmt_emp)) == '1)
      else $error("tx int low, tx empty");
   a_txreq_ready: assert property ((tx_transfer_request & tx_ready_out_n) == '0)
      else $error("tx request, not ready");
   a_rxreq_ready: assert property ((rx_transfer_request & rx_ready_out_n) == '0)
      else $error("rx request, not ready");
   a_irq_fall: assert property (($past(rx_ready_out_n) & ~rx_ready_out_n
      & $past(mask_reg[NCH-1:0])) != '0 |-> irq)
      else $error("ready event, no irq");
endmodule : qsc_status_properties

bind qsc_status_top qsc_status_properties #(.FIFO_DEPTH(FIFO_DEPTH))
   u_props (.*);

// file: sim/qsc_status_top_test.sv
// self-checking bench for the channel status block
module qsc_status_top_test;
   import qsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DEP = 16;
   logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, irq, addr_qual, term_cnt;
   logic term_cmd = 0, pin_chk = 0;
   logic [3:0] dly = '0;
   qsc_chan_in_t [NCH-1:0] chan_in = '0;
   logic [NCH-1:0] ack, txi, rxi, txr, rxr, txq, rxq;
   int errors = 0, cmp_count = 0;
   wire logic [24:0] pins = {irq, rxq, txq, rxr, txr, rxi, txi};
   logic [32:0] rd_q[$];
   logic [24:0] pin_q[$];
   logic [7:0] fctl[NCH] = '{default: '0}, feat[NCH] = '{default: '0};
   logic [7:0] enh[NCH] = '{default: '0};
   logic [15:0] trg[NCH] = '{default: 16'h0101};
   logic [11:0] stat = '0, mask = '0;
   logic [NCH-1:0] held = '0, tcb = '0, prv_rxr = '1, to_ev = '0;
   // reset table: error flag, address, data
   localparam logic [40:0] RV[8] = '{{9'h000, 32'h0}, {9'h004, 32'h0},
      {9'h028, 32'h0}, {9'h00c, 32'h20}, {9'h010, 32'h0101},
      {9'h034, 32'h1}, {9'h018, 32'h3}, {9'h11c, 32'h0}};
   qsc_status_top #(.FIFO_DEPTH(DEP)) dut (
      .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .chan_in(chan_in),
      .transfer_acknowledge(ack), .address_enable_qual(addr_qual),
      .transfer_terminal_count(term_cnt), .tx_int_out(txi),
      .rx_int_out(rxi), .tx_ready_out_n(txr), .rx_ready_out_n(rxr),
      .tx_transfer_request(txq), .rx_transfer_request(rxq), .irq(irq));
   qsc_xfer_model u_xfer (.clock(clock), .rst_n(rst_n), .tx_req(txq),
      .rx_req(rxq), .term_cmd(term_cmd), .dly(dly), .ack(ack),
      .addr_qual(addr_qual), .term_cnt(term_cnt));
   // 10 MHz clock
   initial forever #50 clock = ~clock;
   // one apb transfer; reads note the answer first
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d, input logic [32:0] e);
      if (!wr) rd_q.push_back(e);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // channel register write, mirrored in the bench
   task automatic wreg(input int c, input logic [4:0] o,
         input logic [15:0] d);
      apb(1'b1, {1'b0, 2'(c), o}, {16'h0, d}, '0);
      case (o)
         OFS_FIFO_CTL: fctl[c] = d[7:0];
         OFS_FEAT_CTL: feat[c] = d[7:0];
         OFS_ENH_MODE: enh[c] = d[7:0];
         OFS_TRIG: trg[c] = d;
         default: ;
      endcase
   endtask : wreg
   // new levels on all channels, random or empty
   task automatic set_lvl(input logic rnd);
      @(posedge clock);
      for (int c = 0; c < NCH; c++) begin
         chan_in[c].tx_level <= rnd ? 8'($urandom_range(DEP)) : 8'h00;
         chan_in[c].rx_level <= rnd ? 8'($urandom_range(12)) : 8'h00;
         chan_in[c].tsr_empty <= rnd ? 1'($urandom) : 1'b1;
      end
   endtask : set_lvl
   // expected pins from bench registers and levels
   task automatic chk_pins();
      logic [NCH-1:0] ti, ri, tr, rr, tq, rq;
      logic f, bm, te;
      qsc_lvl_t tl, rl;
      repeat (2) @(posedge clock);
      for (int c = 0; c < NCH; c++) begin
         f = fctl[c][FCR_FIFO_EN];
         bm = f & fctl[c][FCR_BLOCK];
         tl = chan_in[c].tx_level;
         rl = chan_in[c].rx_level;
         te = tl == 0 && (!feat[c][FEATURE_CTL_REG_TX_EMPTY] || chan_in[c].tsr_empty);
         ti[c] = te | (f & (tl < trg[c][7:0]));
         ri[c] = f ? rl >= trg[c][15:8] : rl != 0;
         tr[c] = bm ? tl >= DEP : tl != 0;
         held[c] = bm && rl != 0 && (held[c] || rl >= trg[c][15:8] || to_ev[c]);
         rr[c] = bm ? !held[c] : rl == 0;
         if (prv_rxr[c] & !rr[c]) stat[c] = 1'b1;
         prv_rxr[c] = rr[c];
         if (tr[c] & rr[c]) tcb[c] = 1'b0;
         tq[c] = enh[c][ENH_MODE_SELECT_REG_TX_XFER] & !tr[c] & !tcb[c];
         rq[c] = enh[c][ENH_MODE_SELECT_REG_RX_XFER] & !rr[c] & !tcb[c];
      end
      pin_q.push_back({|(stat & mask), rq, tq, rr, tr, ri, ti});
      pin_chk <= 1'b1;
      @(posedge clock);
      pin_chk <= 1'b0;
   endtask : chk_pins
   task automatic cmp_rd(input logic [32:0] e);
      cmp_count++;
      if ({pslverr, prdata} !== e) begin
         errors++;
         $display("[FAIL] %0t read %h want %h", $time, {pslverr, prdata}, e);
      end
   endtask : cmp_rd
   task automatic cmp_pins(input logic [24:0] e);
      cmp_count++;
      if (pins !== e) begin
         errors++;
         $display("[FAIL] %0t pins %h want %h", $time, pins, e);
      end
   endtask : cmp_pins
   // monitor: pop the oldest note per result
   always @(posedge clock) begin
      if (psel && penable && pready === 1'b1 && !pwrite) cmp_rd(rd_q.pop_front());
      if (pin_chk) cmp_pins(pin_q.pop_front());
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize
   // watchdog, far above the run length
   initial begin
      #(100 * 30000);
      errors++;
      summarize();
   end
   // main sequence
   initial begin
      void'($urandom(32'hd43e));
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      foreach (RV[i]) apb(1'b0, RV[i][39:32], '0, {RV[i][40], RV[i][31:0]});
      for (int c = 0; c < NCH; c++) begin
         for (int m = 0; m < 8; m++) begin
            set_lvl(1'b0);
            chk_pins();
            wreg(c, OFS_FIFO_CTL, {12'h0, m[1], 2'b0, m[0]});
            wreg(c, OFS_FEAT_CTL, {12'h0, m[2], 3'b0});
            wreg(c, OFS_ENH_MODE, 16'($urandom_range(255)));
            wreg(c, OFS_TRIG, {8'($urandom_range(12, 1)), 8'($urandom_range(15, 1))});
            mask = 12'($urandom);
            dly <= 4'($urandom);
            apb(1'b1, 8'h84, {20'h0, mask}, '0);
            apb(1'b0, 8'h80, '0, {21'h0, stat});
            stat = '0;
            repeat (6) begin
               set_lvl(1'b1);
               chk_pins();
               apb(1'b0, {1'b0, 2'(c), OFS_LINE_ST}, '0, {26'h0,
                  chan_in[c].tx_level == 0 && chan_in[c].tsr_empty,
                  chan_in[c].tx_level == 0, 5'h0});
            end
         end
      end
      // block-mode timeout on channel 1, restarted by a host read
      set_lvl(1'b0);
      wreg(1, OFS_FIFO_CTL, 16'h0009);
      wreg(1, OFS_TRIG, 16'h0801);
      apb(1'b1, 8'h38, 32'h0, '0);
      @(posedge clock);
      chan_in[1].rx_level <= 8'h02;
      chk_pins();
      repeat (400) @(posedge clock);
      chan_in[1].rx_pop <= 1'b1;
      @(posedge clock);
      chan_in[1].rx_pop <= 1'b0;
      repeat (600) @(posedge clock);
      chk_pins();
      repeat (100) @(posedge clock);
      to_ev[1] = 1'b1;
      stat[5] = 1'b1;
      chk_pins();
      to_ev[1] = 1'b0;
      set_lvl(1'b0);
      chk_pins();
      // terminal count parks requests until both ready pins idle
      for (int c = 0; c < NCH; c++) wreg(c, OFS_ENH_MODE, c == 0 ? 16'h8 : 16'h0);
      wreg(0, OFS_FIFO_CTL, 16'h0000);
      dly <= 4'h9;
      chk_pins();
      term_cmd <= 1'b1;
      repeat (30) @(posedge clock);
      term_cmd <= 1'b0;
      tcb[0] = 1'b1;
      stat[8] = 1'b1;
      chk_pins();
      @(posedge clock);
      chan_in[0].tx_level <= 8'h01;
      chk_pins();
      set_lvl(1'b0);
      chk_pins();
      apb(1'b0, 8'h80, '0, {21'h0, stat});
      summarize();
   end
endmodule : qsc_status_top_test

// file: sim/qsc_xfer_model.sv
// transfer controller model answering the request lines
module qsc_xfer_model (
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   input  wire logic [qsc_pkg::NCH-1:0] tx_req,
   input  wire logic [qsc_pkg::NCH-1:0] rx_req,
   input  wire logic                    term_cmd,
   input  wire logic [3:0]              dly,
   output logic      [qsc_pkg::NCH-1:0] ack,
   output logic                         addr_qual,
   output logic                         term_cnt
);
   import qsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0]     cnt;
   logic [NCH-1:0] want;
   // one channel served at a time, lowest first
   assign want = tx_req | rx_req;
   // wait dly cycles, then ack for one cycle
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n || ack != '0 || want == '0) begin
         cnt <= '0;
         ack <= '0;
         addr_qual <= 1'b0;
         term_cnt <= 1'b0;
      end else if (cnt < dly) begin
         cnt <= cnt + 4'h1;
      end else begin
         ack <= want & (~want + 4'h1);
         addr_qual <= 1'b1;
         term_cnt <= term_cmd;
      end
   end
endmodule : qsc_xfer_model
